/* src/hvf_map.svh */
// Address map, field layout, word counts and reset values of the coefficient loader.
`ifndef HVF_MAP_SVH
`define HVF_MAP_SVH
`define HVF_OFS_COEF 12'h000
`define HVF_OFS_CFG 12'h200
`define HVF_OFS_HSEL 12'h400
`define HVF_OFS_VSEL 12'h600
`define HVF_OFS_HROUND 12'h800
`define HVF_OFS_VROUND 12'ha00
`define HVF_OFS_HCLAMP 12'hc00
`define HVF_OFS_VCLAMP 12'he00
`define HVF_CLASS_LSB 9
`define HVF_WORDS_COEF 4'h8
`define HVF_WORDS_ONE 4'h1
`define HVF_WORDS_ROUND 4'h4
`define HVF_WORDS_CLAMP 4'h2
`define HVF_ROUND_PART_W 8
`define HVF_CFG_COUNT 6
`define HVF_CFG_LIMIT 3'h5
`define HVF_CFG_VLIM_BIT 0
`define HVF_CFG_HLIM_BIT 1
`define HVF_CLAMP_LO_MSB 11
`define HVF_CLAMP_HI_LSB 12
`define HVF_CLAMP_HI_MSB 23
`define HVF_RESET_WORD 12'h000
`endif

/* src/hvf_pkg.sv */
// Types shared by the coefficient loader modules.
package hvf_pkg;
`include "hvf_map.svh"
   typedef logic [11:0] hvf_word_t;
   typedef logic [4:0] hvf_sel_t;
   typedef logic [23:0] hvf_clamp_t;
   typedef logic [31:0] hvf_round_t;
   typedef logic [3:0] hvf_idx_t;
   typedef enum logic [2:0] {
      HVF_CLS_COEF = 3'(`HVF_OFS_COEF >> `HVF_CLASS_LSB),
      HVF_CLS_CFG = 3'(`HVF_OFS_CFG >> `HVF_CLASS_LSB),
      HVF_CLS_HSEL = 3'(`HVF_OFS_HSEL >> `HVF_CLASS_LSB),
      HVF_CLS_VSEL = 3'(`HVF_OFS_VSEL >> `HVF_CLASS_LSB),
      HVF_CLS_HROUND = 3'(`HVF_OFS_HROUND >> `HVF_CLASS_LSB),
      HVF_CLS_VROUND = 3'(`HVF_OFS_VROUND >> `HVF_CLASS_LSB),
      HVF_CLS_HCLAMP = 3'(`HVF_OFS_HCLAMP >> `HVF_CLASS_LSB),
      HVF_CLS_VCLAMP = 3'(`HVF_OFS_VCLAMP >> `HVF_CLASS_LSB)
   } hvf_class_t;
   typedef enum logic {
      HVF_ST_ADDR = 1'b0,
      HVF_ST_DATA = 1'b1
   } hvf_load_state_t;
endpackage

/* src/hvf_stream_if.sv */
// Valid/ready word stream between the loader's own modules.
`timescale 1ns/1ps
interface hvf_stream_if #(parameter int W = 36);
   logic [W-1:0] data;
   logic valid;
   logic ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

/* src/hvf_fifo.sv */
// Flip-flop FIFO with registered full and empty flags.
`timescale 1ns/1ps
module hvf_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Streams
   hvf_stream_if.snk inPort,
   hvf_stream_if.src outPort
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_check
      $error("hvf_fifo: DEPTH must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wrPtr_r;
   logic [PW-1:0] rdPtr_r;
   logic [CW-1:0] count_r;
   logic [CW-1:0] count_nxt;
   logic notFull_r;
   logic notEmpty_r;
   logic push;
   logic pop;

   assign push = inPort.valid && notFull_r;
   assign pop = outPort.ready && notEmpty_r;
   assign inPort.ready = notFull_r;
   assign outPort.valid = notEmpty_r;
   assign outPort.data = mem[rdPtr_r];

   always_comb begin
      count_nxt = count_r;
      if (push && !pop) begin
         count_nxt = CW'(count_r + 1'b1);
      end else if (pop && !push) begin
         count_nxt = CW'(count_r - 1'b1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wrPtr_r] <= inPort.data;
      end
   end

   // Flags are registered so the source sees a ready that never ripples from the sink.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
         notFull_r <= 1'b1;
         notEmpty_r <= 1'b0;
      end else begin
         wrPtr_r <= push ? PW'(wrPtr_r + 1'b1) : wrPtr_r;
         rdPtr_r <= pop ? PW'(rdPtr_r + 1'b1) : rdPtr_r;
         count_r <= count_nxt;
         notFull_r <= (count_nxt != CW'(DEPTH));
         notEmpty_r <= (count_nxt != '0);
      end
   end
endmodule

/* src/hvf_coef_loader.sv */
// Coefficient and control register loader with the vertical window and clamp stage.
`timescale 1ns/1ps
`include "hvf_map.svh"
module hvf_coef_loader
   import hvf_pkg::*;
#(
   parameter int RES_W = 32,
   parameter int NUM_BANKS = 8,
   parameter int COEF_DEPTH = 256,
   parameter int NUM_REGS = 16,
   parameter int FIFO_DEPTH = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Horizontal loading port
   input wire logic horiz_load_enable_n,
   input wire logic [11:0] horiz_load_word,
   input wire logic horiz_load_hold,
   // Vertical loading port
   input wire logic vert_load_enable_n,
   input wire logic [11:0] vert_load_word,
   input wire logic vert_load_hold,
   // Register indices
   input wire logic [3:0] horiz_reg_index,
   input wire logic [3:0] vert_reg_index,
   // Coefficient read side
   input wire logic [7:0] horizCoefAddr,
   input wire logic [7:0] vertCoefAddr,
   output logic [NUM_BANKS-1:0][11:0] horizCoefs,
   output logic [NUM_BANKS-1:0][11:0] vertCoefs,
   // Selected control values
   output logic [31:0] horizRound,
   output logic [4:0] horizWindow,
   output logic [23:0] horizClamp,
   output logic horizLimitEnable,
   output logic [31:0] vertRound,
   output logic vertLimitEnable,
   output logic [`HVF_CFG_COUNT-1:0][11:0] cfgWords,
   // Vertical result stream
   input wire logic [RES_W-1:0] vertResult,
   input wire logic vertResultValid,
   output logic vertResultReady,
   output logic [11:0] vertOut,
   output logic vertOutValid,
   input wire logic vertOutReady
);
   if (RES_W < $bits(hvf_word_t) || RES_W > 64 || NUM_BANKS != int'(`HVF_WORDS_COEF) ||
       COEF_DEPTH != 256 || NUM_REGS != 16) begin : g_check
      $error("hvf_coef_loader: unsupported parameter values");
   end

   localparam int P_H = 0;
   localparam int P_V = 1;
   function automatic logic [3:0] wordsFor(input hvf_class_t c);
      logic [3:0] n;
      n = `HVF_WORDS_ONE;
      unique case (c)
         HVF_CLS_COEF: n = `HVF_WORDS_COEF;
         HVF_CLS_HROUND, HVF_CLS_VROUND: n = `HVF_WORDS_ROUND;
         HVF_CLS_HCLAMP, HVF_CLS_VCLAMP: n = `HVF_WORDS_CLAMP;
         HVF_CLS_CFG, HVF_CLS_HSEL, HVF_CLS_VSEL: n = `HVF_WORDS_ONE;
      endcase
      return n;
   endfunction

   // Pins of both ports, index 0 horizontal and 1 vertical.
   logic rawEnN [2];
   hvf_word_t rawWord [2];
   logic rawHold [2];
   hvf_idx_t rawIdx [2];
   logic enNS1 [2];
   logic enNS2 [2];
   hvf_word_t wordS1 [2];
   hvf_word_t wordS2 [2];
   logic holdS1 [2];
   logic holdS2 [2];
   hvf_idx_t idxS1 [2];
   hvf_idx_t idxS2 [2];
   // Loader state per port.
   hvf_load_state_t state_r [2];
   logic [3:0] cnt_r [2];
   logic [3:0] need_r [2];
   hvf_class_t cls_r [2];
   logic [8:0] loc_r [2];
   logic commit_r [2];
   hvf_word_t buf_r [2][`HVF_WORDS_COEF];
   assign rawEnN[P_H] = horiz_load_enable_n;
   assign rawEnN[P_V] = vert_load_enable_n;
   assign rawWord[P_H] = horiz_load_word;
   assign rawWord[P_V] = vert_load_word;
   assign rawHold[P_H] = horiz_load_hold;
   assign rawHold[P_V] = vert_load_hold;
   assign rawIdx[P_H] = horiz_reg_index;
   assign rawIdx[P_V] = vert_reg_index;
   for (genvar p = 0; p < 2; p++) begin : g_port
      always_ff @(posedge sys_clk) begin
         if (rst) begin
            enNS1[p] <= 1'b1;
            enNS2[p] <= 1'b1;
            holdS1[p] <= 1'b0;
            holdS2[p] <= 1'b0;
         end else begin
            enNS1[p] <= rawEnN[p];
            enNS2[p] <= enNS1[p];
            holdS1[p] <= rawHold[p];
            holdS2[p] <= holdS1[p];
         end
      end

      always_ff @(posedge sys_clk) begin
         wordS1[p] <= rawWord[p];
         wordS2[p] <= wordS1[p];
         idxS1[p] <= rawIdx[p];
         idxS2[p] <= idxS1[p];
      end

      always_ff @(posedge sys_clk) begin
         if (rst) begin
            state_r[p] <= HVF_ST_ADDR;
            cnt_r[p] <= '0;
            need_r[p] <= `HVF_WORDS_ONE;
            cls_r[p] <= HVF_CLS_COEF;
            loc_r[p] <= '0;
            commit_r[p] <= 1'b0;
         end else begin
            commit_r[p] <= 1'b0;
            if (holdS2[p]) begin
               state_r[p] <= state_r[p];
            end else if (enNS2[p]) begin
               state_r[p] <= HVF_ST_ADDR;
            end else begin
               unique case (state_r[p])
                  HVF_ST_ADDR: begin
                     cls_r[p] <= hvf_class_t'(wordS2[p][11:9]);
                     loc_r[p] <= wordS2[p][8:0];
                     need_r[p] <= wordsFor(hvf_class_t'(wordS2[p][11:9]));
                     cnt_r[p] <= '0;
                     state_r[p] <= HVF_ST_DATA;
                  end
                  HVF_ST_DATA: begin
                     cnt_r[p] <= 4'(cnt_r[p] + 1'b1);
                     if (cnt_r[p] == 4'(need_r[p] - 1'b1)) begin
                        commit_r[p] <= 1'b1;
                        state_r[p] <= HVF_ST_ADDR;
                     end
                  end
               endcase
            end
         end
      end

      always_ff @(posedge sys_clk) begin
         if (!holdS2[p] && !enNS2[p] && state_r[p] == HVF_ST_DATA) begin
            buf_r[p][cnt_r[p][2:0]] <= wordS2[p];
         end
      end
   end
   // Coefficient banks, one per multiplier and filter.
   hvf_word_t coefH [NUM_BANKS][COEF_DEPTH];
   hvf_word_t coefV [NUM_BANKS][COEF_DEPTH];
   logic wrCoefH;
   logic wrCoefV;
   assign wrCoefH = commit_r[P_H] && cls_r[P_H] == HVF_CLS_COEF && !loc_r[P_H][8];
   assign wrCoefV = commit_r[P_V] && cls_r[P_V] == HVF_CLS_COEF && !loc_r[P_V][8];
   for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      always_ff @(posedge sys_clk) begin
         if (wrCoefH) begin
            coefH[b][loc_r[P_H][7:0]] <= buf_r[P_H][b];
         end
         if (wrCoefV) begin
            coefV[b][loc_r[P_V][7:0]] <= buf_r[P_V][b];
         end
      end

      always_ff @(posedge sys_clk) begin
         if (rst) begin
            horizCoefs[b] <= '0;
            vertCoefs[b] <= '0;
         end else begin
            horizCoefs[b] <= coefH[b][horizCoefAddr];
            vertCoefs[b] <= coefV[b][vertCoefAddr];
         end
      end
   end

   // Control and configuration writes; the vertical port wins a collision.
   hvf_round_t roundRegs [2][NUM_REGS];
   hvf_sel_t selRegs [2][NUM_REGS];
   hvf_clamp_t clampRegs [2][NUM_REGS];
   hvf_word_t cfgRegs [`HVF_CFG_COUNT];
   logic ctlV;
   logic ctlH;
   logic winner;
   hvf_class_t wCls;
   logic [8:0] wLoc;
   hvf_round_t wRound;
   hvf_clamp_t wClamp;
   hvf_word_t wFirst;
   assign ctlV = commit_r[P_V] && cls_r[P_V] != HVF_CLS_COEF;
   assign ctlH = commit_r[P_H] && cls_r[P_H] != HVF_CLS_COEF && !ctlV;
   assign winner = ctlV;
   assign wCls = cls_r[winner];
   assign wLoc = loc_r[winner];
   assign wFirst = buf_r[winner][0];
   assign wClamp = {buf_r[winner][1], buf_r[winner][0]};
   // Only the low byte of each round word carries data; the rest is reserved.
   always_comb begin
      wRound = '0;
      for (int i = 0; i < int'(`HVF_WORDS_ROUND); i++) begin
         wRound[i*`HVF_ROUND_PART_W +: `HVF_ROUND_PART_W] =
            buf_r[winner][i][`HVF_ROUND_PART_W-1:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         roundRegs <= '{default: '0};
         selRegs <= '{default: '0};
         clampRegs <= '{default: '0};
         cfgRegs <= '{default: `HVF_RESET_WORD};
      end else if ((ctlV || ctlH) && wLoc[8:4] == '0) begin
         unique case (wCls)
            HVF_CLS_CFG: begin
               if (int'(wLoc[3:0]) < `HVF_CFG_COUNT) begin
                  cfgRegs[wLoc[2:0]] <= wFirst;
               end
            end
            HVF_CLS_HSEL: selRegs[P_H][wLoc[3:0]] <= wFirst[4:0];
            HVF_CLS_VSEL: selRegs[P_V][wLoc[3:0]] <= wFirst[4:0];
            HVF_CLS_HROUND: roundRegs[P_H][wLoc[3:0]] <= wRound;
            HVF_CLS_VROUND: roundRegs[P_V][wLoc[3:0]] <= wRound;
            HVF_CLS_HCLAMP: clampRegs[P_H][wLoc[3:0]] <= wClamp;
            HVF_CLS_VCLAMP: clampRegs[P_V][wLoc[3:0]] <= wClamp;
            HVF_CLS_COEF: ;
         endcase
      end
   end
   // Per-cycle selected values for the filter datapaths.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         horizRound <= '0;
         horizWindow <= '0;
         horizClamp <= '0;
         horizLimitEnable <= 1'b0;
         vertRound <= '0;
         vertLimitEnable <= 1'b0;
         cfgWords <= '0;
      end else begin
         horizRound <= roundRegs[P_H][idxS2[P_H]];
         horizWindow <= selRegs[P_H][idxS2[P_H]];
         horizClamp <= clampRegs[P_H][idxS2[P_H]];
         horizLimitEnable <= cfgRegs[`HVF_CFG_LIMIT][`HVF_CFG_HLIM_BIT];
         vertRound <= roundRegs[P_V][idxS2[P_V]];
         vertLimitEnable <= cfgRegs[`HVF_CFG_LIMIT][`HVF_CFG_VLIM_BIT];
         for (int i = 0; i < `HVF_CFG_COUNT; i++) begin
            cfgWords[i] <= cfgRegs[i];
         end
      end
   end

   // Vertical output stage; the index travels with its result through the FIFO.
   hvf_stream_if #(.W(RES_W + 4)) fifoIn ();
   hvf_stream_if #(.W(RES_W + 4)) fifoOut ();
   assign fifoIn.data = {idxS2[P_V], vertResult};
   assign fifoIn.valid = vertResultValid;
   assign vertResultReady = fifoIn.ready;
   hvf_fifo #(
      .WIDTH(RES_W + 4),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .inPort(fifoIn),
      .outPort(fifoOut)
   );

   hvf_idx_t fIdx;
   logic [RES_W-1:0] fRes;
   logic [RES_W-1:0] shifted;
   hvf_word_t window;
   hvf_word_t lowLim;
   hvf_word_t highLim;
   hvf_word_t limited;
   logic limOn;
   logic take;
   assign fIdx = fifoOut.data[RES_W +: 4];
   assign fRes = fifoOut.data[RES_W-1:0];
   assign take = fifoOut.valid && fifoOut.ready;
   assign fifoOut.ready = !vertOutValid || vertOutReady;
   assign limOn = cfgRegs[`HVF_CFG_LIMIT][`HVF_CFG_VLIM_BIT];
   assign lowLim = clampRegs[P_V][fIdx][`HVF_CLAMP_LO_MSB:0];
   assign highLim = clampRegs[P_V][fIdx][`HVF_CLAMP_HI_MSB:`HVF_CLAMP_HI_LSB];
   always_comb begin
      shifted = fRes >> selRegs[P_V][fIdx];
      window = shifted[11:0];
      limited = window;
      if (limOn && $signed(window) < $signed(lowLim)) begin
         limited = lowLim;
      end else if (limOn && $signed(window) > $signed(highLim)) begin
         limited = highLim;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         vertOut <= '0;
         vertOutValid <= 1'b0;
      end else if (take) begin
         vertOut <= limited;
         vertOutValid <= 1'b1;
      end else if (vertOutReady) begin
         vertOutValid <= 1'b0;
      end
   end

   // Checks on the loading sequence and the output stage.
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   property p_idle_h;
      enNS2[P_H] && !holdS2[P_H] |=> state_r[P_H] == HVF_ST_ADDR && !commit_r[P_H];
   endproperty
   a_idle_h: assert property (p_idle_h) else $error("horizontal port active while disabled");
   property p_hold_v;
      holdS2[P_V] |=> $stable(state_r[P_V]) && $stable(cnt_r[P_V]) && !commit_r[P_V];
   endproperty
   a_hold_v: assert property (p_hold_v) else $error("vertical port moved while held");
   property p_commit_count;
      commit_r[P_H] |-> $past(cnt_r[P_H]) == 4'(wordsFor(cls_r[P_H]) - 1'b1);
   endproperty
   a_commit_count: assert property (p_commit_count) else $error("wrong data word count");
   property p_next_addr;
      commit_r[P_V] |-> state_r[P_V] == HVF_ST_ADDR;
   endproperty
   a_next_addr: assert property (p_next_addr) else $error("no address after last word");
   property p_cfg_stable;
      !commit_r[P_H] && !commit_r[P_V] |=> $stable(cfgRegs[`HVF_CFG_LIMIT]);
   endproperty
   a_cfg_stable: assert property (p_cfg_stable) else $error("config written early");
   property p_vert_wins;
      commit_r[P_V] && cls_r[P_V] == HVF_CLS_CFG && loc_r[P_V] < 9'(`HVF_CFG_COUNT) &&
         commit_r[P_H] && cls_r[P_H] == HVF_CLS_CFG
         |=> cfgRegs[$past(loc_r[P_V][2:0])] == $past(buf_r[P_V][0]);
   endproperty
   a_vert_wins: assert property (p_vert_wins) else $error("horizontal write won");
   property p_clamp_low;
      take && limOn && $signed(window) < $signed(lowLim) |=> vertOut == $past(lowLim);
   endproperty
   a_clamp_low: assert property (p_clamp_low) else $error("lower limit not applied");
   property p_clamp_high;
      take && limOn && $signed(window) > $signed(highLim) |=> vertOut == $past(highLim);
   endproperty
   a_clamp_high: assert property (p_clamp_high) else $error("upper limit not applied");
   property p_pass;
      take && !limOn |=> vertOutValid && vertOut == 12'($past(fRes >> selRegs[P_V][fIdx]));
   endproperty
   a_pass: assert property (p_pass) else $error("window altered without limiting");
   property p_coef_bank7;
      wrCoefH |=> coefH[7][$past(loc_r[P_H][7:0])] == $past(buf_r[P_H][7]);
   endproperty
   a_coef_bank7: assert property (p_coef_bank7) else $error("bank 7 not written");
endmodule

/* testbench/hvf_host_model.sv */
// Host model that feeds address and data words into both loading ports.
`timescale 1ns/1ps
module hvf_host_model
   import hvf_pkg::*;
(
   // Clock
   input wire logic sys_clk,
   // Horizontal port
   output logic hEnN,
   output logic [11:0] hWord,
   output logic hHold,
   // Vertical port
   output logic vEnN,
   output logic [11:0] vWord,
   output logic vHold
);
   initial begin
      hEnN = 1'b1;
      vEnN = 1'b1;
      hWord = 12'h000;
      vWord = 12'h000;
      hHold = 1'b0;
      vHold = 1'b0;
   end

   // Words go out back to back; a hold cycle inserted at holdAt shows garbage on both ports.
   task automatic send(input hvf_word_t hq[$], input hvf_word_t vq[$], input int holdAt);
      int n;
      int i;
      n = (hq.size() > vq.size()) ? hq.size() : vq.size();
      i = 0;
      while (i < n) begin
         @(posedge sys_clk);
         #1;
         hHold = (i == holdAt);
         vHold = (i == holdAt);
         if (i == holdAt) begin
            holdAt = -1;
            hWord = ~hWord;
            vWord = ~vWord;
         end else begin
            hEnN = (i >= hq.size());
            vEnN = (i >= vq.size());
            hWord = (i < hq.size()) ? hq[i] : ~hWord;
            vWord = (i < vq.size()) ? vq[i] : ~vWord;
            i++;
         end
      end
      @(posedge sys_clk);
      #1;
      hEnN = 1'b1;
      vEnN = 1'b1;
      hWord = ~hWord;
      vWord = ~vWord;
   endtask
endmodule

/* testbench/hvf_coef_loader_tb.sv */
// Self-checking bench for the coefficient loader and vertical output stage.
`timescale 1ns/1ps
module hvf_coef_loader_tb
   import hvf_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic hEnN, hHold, vEnN, vHold, vertResultValid, vertResultReady, vertOutValid;
   logic vertOutReady = 1'b1;
   logic [11:0] hWord, vWord, vertOut;
   logic [3:0] hIdx = 4'h0;
   logic [3:0] vIdx = 4'h3;
   logic [7:0] vCoefAddr = 8'h0a;
   logic [7:0][11:0] hCoefs, vCoefs;
   logic [31:0] hRound, vRound, vertResult;
   logic [4:0] hWin;
   logic [23:0] hClamp;
   logic hLim, vLim;
   logic [5:0][11:0] cfg;
   int bad_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   hvf_word_t cw[8] = '{12'h210, 12'h543, 12'hc76, 12'h9e3, 12'h701, 12'h832, 12'hf20, 12'h143};

   initial forever #50 sys_clk = ~sys_clk;

   hvf_host_model i_host (.sys_clk(sys_clk), .hEnN(hEnN), .hWord(hWord), .hHold(hHold),
      .vEnN(vEnN), .vWord(vWord), .vHold(vHold));

   hvf_coef_loader i_dut (.sys_clk(sys_clk), .rst(rst), .horiz_load_enable_n(hEnN),
      .horiz_load_word(hWord), .horiz_load_hold(hHold), .vert_load_enable_n(vEnN),
      .vert_load_word(vWord), .vert_load_hold(vHold), .horiz_reg_index(hIdx),
      .vert_reg_index(vIdx), .horizCoefAddr(vCoefAddr), .vertCoefAddr(vCoefAddr),
      .horizCoefs(hCoefs), .vertCoefs(vCoefs), .horizRound(hRound), .horizWindow(hWin),
      .horizClamp(hClamp), .horizLimitEnable(hLim), .vertRound(vRound),
      .vertLimitEnable(vLim), .cfgWords(cfg), .vertResult(vertResult),
      .vertResultValid(vertResultValid), .vertResultReady(vertResultReady),
      .vertOut(vertOut), .vertOutValid(vertOutValid), .vertOutReady(vertOutReady));

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   // Waits a bounded time for an output word, checks it and lets one handshake pass.
   task automatic get_out(input hvf_word_t exp);
      int k;
      k = 0;
      while (vertOutValid !== 1'b1 && k < 20) begin
         step(1);
         k++;
      end
      check("vertOutValid", 32'(vertOutValid), 32'h1);
      check("vertOut", 32'(vertOut), 32'(exp));
      step(1);
   endtask

   task automatic push(input logic [31:0] r, input hvf_word_t exp);
      vertResult = r;
      vertResultValid = 1'b1;
      while (vertResultReady !== 1'b1) step(1);
      step(1);
      vertResultValid = 1'b0;
      get_out(exp);
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         print_verdict();
      end
   end

   initial begin
      int n;
      logic rdy;
      vertResult = 32'h0;
      vertResultValid = 1'b0;
      step(12);
      rst = 1'b0;
      hIdx = 4'hc;
      i_host.send('{12'h80c, 12'h0a2, 12'h0f4, 12'h083, 12'h076}, '{}, 2);
      step(8);
      check("horizRound", hRound, 32'h7683f4a2);
      i_host.send('{12'h402, 12'h00f, 12'hc0a, 12'h390, 12'h743}, '{}, -1);
      hIdx = 4'h2;
      step(8);
      check("horizWindow", 32'(hWin), 32'h0f);
      hIdx = 4'ha;
      step(8);
      check("horizClamp", 32'(hClamp), 32'h743390);
      $display("test register loads done");
      i_host.send('{12'h200, 12'h0aa, 12'h205, 12'h002}, '{12'h200, 12'h055}, -1);
      step(8);
      check("cfg0", 32'(cfg[0]), 32'h055);
      check("horizLimitEnable", 32'(hLim), 32'h1);
      $display("test collision done");
      i_host.send('{12'h00a, cw[7], cw[6], cw[5], cw[4], cw[3], cw[2], cw[1], cw[0]},
         '{12'h00a, cw[0], cw[1], cw[2], cw[3], cw[4], cw[5], cw[6], cw[7]}, 4);
      step(8);
      for (int b = 0; b < 8; b++) check("vertCoefs", 32'(vCoefs[b]), 32'(cw[b]));
      for (int b = 0; b < 8; b++) check("horizCoefs", 32'(hCoefs[b]), 32'(cw[7-b]));
      $display("test coefficient load done");
      i_host.send('{}, '{12'h603, 12'h004, 12'he03, 12'h100, 12'h200, 12'h205, 12'h001,
         12'ha03, 12'h011, 12'h022, 12'h033, 12'h044}, -1);
      step(8);
      check("vertLimitEnable", 32'(vLim), 32'h1);
      check("vertRound", vRound, 32'h44332211);
      push(32'h00000500, 12'h100);
      push(32'h00003000, 12'h200);
      push(32'hf0001500, 12'h150);
      i_host.send('{}, '{12'h205, 12'h000}, -1);
      step(8);
      push(32'h00003000, 12'h300);
      $display("test window and clamp done");
      vertOutReady = 1'b0;
      vertResultValid = 1'b1;
      n = 0;
      repeat (14) begin
         vertResult = 32'(n) << 4;
         rdy = vertResultReady;
         step(1);
         if (rdy === 1'b1) n++;
      end
      vertResultValid = 1'b0;
      check("refused", 32'(vertResultReady), 32'h0);
      check("taken", 32'(n), 32'h9);
      vertOutReady = 1'b1;
      for (int i = 0; i < n; i++) get_out(12'(i));
      check("drained", 32'(vertOutValid), 32'h0);
      $display("test buffer fill and drain done");
      print_verdict();
   end
endmodule
